/* include/ldcfg_regs.svh */
// Index offsets, reset values and decode constants of the logical device configuration bank
`ifndef LDCFG_REGS_SVH
`define LDCFG_REGS_SVH

`define CFG_PORT_DEFAULT 16'h002E
`define IDX_LDN 8'h07
`define IDX_ACTIVATE 8'h30
`define IDX_BASE_HI 8'h60
`define IDX_BASE_LO 8'h61
`define IDX_IRQ_PRI 8'h70
`define IDX_RSVD_71 8'h71
`define IDX_IRQ_SEC 8'h72
`define IDX_RSVD_73 8'h73
`define IDX_DMA_SEL 8'h74
`define IDX_RSVD_75 8'h75
`define IDX_UNIMP_A_LO 8'h76
`define IDX_UNIMP_A_HI 8'hA8
`define IDX_UNIMP_B_LO 8'hA9
`define IDX_UNIMP_B_HI 8'hDF
`define IDX_VENDOR_LO 8'hE0
`define IDX_VENDOR_HI 8'hFE
`define IDX_RSVD_FF 8'hFF

`define LDN_FLOPPY 4'h0
`define LDN_PARALLEL 4'h3
`define LDN_SERIAL 4'h4
`define LDN_MIDI 4'h5
`define LDN_KEYBOARD 4'h7
`define LDN_GAME 4'h9

`define DMA_RST_FLOPPY 8'h02
`define DMA_RST_PARALLEL 8'h04
`define IRQ_SEC_RST 8'h00

`define BASE_MIN 16'h0100
`define BASE_MAX_8 16'h0FF8
`define BASE_MAX_4 16'h0FFC
`define BASE_MAX_1 16'h0FFF
`define PP_EXT_OFFSET 12'h400
`define KBD_DATA_ADDR 16'h0060
`define KBD_CMD_ADDR 16'h0064
`define FLOPPY_HOLE_OFS 3'h6
`define ACT_BIT 0

`endif

/* include/ldcfg_pkg.sv */
// Types shared by the logical device configuration bank
package ldcfg_pkg;

   // Host I/O cycle as seen by the decoder
   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } io_req_t;

   // Per-function configuration handed to the function logic
   typedef struct packed {
      logic active;
      logic irq_edge_high;
      logic [15:0] base;
      logic [7:0] irq;
      logic [7:0] irq2;
      logic [7:0] dma;
   } ld_cfg_t;

   typedef enum logic [2:0] {
      FN_NONE,
      FN_FLOPPY,
      FN_PARALLEL,
      FN_SERIAL,
      FN_MIDI,
      FN_KEYBOARD,
      FN_GAME
   } fn_kind_t;

endpackage

/* core/ldcfg_bank.sv */
// Logical device configuration bank with function I/O decode
`timescale 1ns/10ps
`include "ldcfg_regs.svh"

module ldcfg_bank
   import ldcfg_pkg::*;
#(
   parameter int NDEV = 10,
   parameter logic [15:0] CFG_PORT = `CFG_PORT_DEFAULT,
   parameter logic [7:0] IRQ_RST_FLOPPY = 8'h06,
   parameter logic [7:0] IRQ_RST_PARALLEL = 8'h07,
   parameter logic [7:0] IRQ_RST_SERIAL = 8'h04,
   parameter logic [7:0] IRQ_RST_MIDI = 8'h05,
   parameter logic [7:0] IRQ_RST_KEYBOARD = 8'h01,
   parameter logic [7:0] IRQ_RST_GAME = 8'h00
)
(
   // Clock and resets
   input logic sys_clk_i,
   input logic rst_b_i,
   input logic soft_reset_i,
   // Host I/O cycles and configuration state
   input io_req_t io_req_i,
   input logic cfg_state_i,
   input logic addr16_qual_i,
   output logic cfg_claim_o,
   output logic [7:0] io_rdata_o,
   output logic io_rvalid_o,
   // Power/control bits of the functions
   input logic [NDEV-1:0] pwr_wr_i,
   input logic [NDEV-1:0] pwr_wdata_i,
   output logic [NDEV-1:0] dev_on_o,
   // Function-specific vendor registers
   input logic [7:0] vendor_rdata_i,
   output logic vendor_wr_o,
   output logic [7:0] vendor_idx_o,
   output logic [7:0] vendor_ldn_o,
   output logic [7:0] vendor_wdata_o,
   // Per-function configuration and selects
   output ld_cfg_t [NDEV-1:0] ld_cfg_o,
   output logic [NDEV-1:0] fn_sel_o,
   output logic pp_epp_ok_o
);

   if (NDEV < 10 || NDEV > 16)
   begin : g_ndev_check
      $error("NDEV must lie between 10 and 16");
   end

   // ****************************************************
   // Helper functions
   // ****************************************************
   function automatic fn_kind_t fn_kind(input logic [7:0] ldn);
      fn_kind_t k;
      k = FN_NONE;
      if (ldn[7:4] == 4'h0)
      begin
         unique case (ldn[3:0])
            `LDN_FLOPPY: k = FN_FLOPPY;
            `LDN_PARALLEL: k = FN_PARALLEL;
            `LDN_SERIAL: k = FN_SERIAL;
            `LDN_MIDI: k = FN_MIDI;
            `LDN_KEYBOARD: k = FN_KEYBOARD;
            `LDN_GAME: k = FN_GAME;
            default: k = FN_NONE;
         endcase
      end
      return k;
   endfunction

   // Reset value of the primary interrupt select per function
   function automatic logic [7:0] irq_rst(input fn_kind_t k);
      logic [7:0] v;
      v = 8'h00;
      unique case (k)
         FN_FLOPPY: v = IRQ_RST_FLOPPY;
         FN_PARALLEL: v = IRQ_RST_PARALLEL;
         FN_SERIAL: v = IRQ_RST_SERIAL;
         FN_MIDI: v = IRQ_RST_MIDI;
         FN_KEYBOARD: v = IRQ_RST_KEYBOARD;
         FN_GAME: v = IRQ_RST_GAME;
         FN_NONE: v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic [7:0] dma_rst(input fn_kind_t k);
      logic [7:0] v;
      v = 8'h00;
      if (k == FN_FLOPPY)
      begin
         v = `DMA_RST_FLOPPY;
      end
      else if (k == FN_PARALLEL)
      begin
         v = `DMA_RST_PARALLEL;
      end
      return v;
   endfunction

   function automatic logic relocatable(input fn_kind_t k);
      return k != FN_NONE && k != FN_KEYBOARD;
   endfunction

   // Programmed base lies inside the permitted range of the function
   function automatic logic base_ok(input fn_kind_t k, input logic [15:0] b);
      logic ok;
      ok = 1'b0;
      unique case (k)
         FN_FLOPPY, FN_SERIAL, FN_MIDI: ok = b >= `BASE_MIN && b <= `BASE_MAX_8 && b[2:0] == 3'h0;
         FN_PARALLEL: ok = b >= `BASE_MIN && b <= `BASE_MAX_4 && b[1:0] == 2'h0;
         FN_GAME: ok = b >= `BASE_MIN && b <= `BASE_MAX_1;
         FN_KEYBOARD: ok = 1'b1;
         FN_NONE: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // ****************************************************
   // Configuration registers
   // ****************************************************
   logic [7:0] index_reg, index_next;
   logic [7:0] ldn_reg, ldn_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic vwr_reg, vwr_next;
   logic [7:0] vwdata_reg, vwdata_next;
   logic [NDEV-1:0] act_reg, act_next;
   logic [7:0] base_hi_reg [NDEV];
   logic [7:0] base_hi_next [NDEV];
   logic [7:0] base_lo_reg [NDEV];
   logic [7:0] base_lo_next [NDEV];
   logic [7:0] irq_reg [NDEV];
   logic [7:0] irq_next [NDEV];
   logic [7:0] irq2_reg [NDEV];
   logic [7:0] irq2_next [NDEV];
   logic [7:0] dma_reg [NDEV];
   logic [7:0] dma_next [NDEV];

   logic idx_hit, dat_hit;
   logic [3:0] cur;
   fn_kind_t cur_kind;
   logic [7:0] bank_rdata;

   // Index and data ports answer only in configuration state
   assign idx_hit = cfg_state_i && io_req_i.addr == CFG_PORT;
   assign dat_hit = cfg_state_i && io_req_i.addr == CFG_PORT + 16'h0001;
   assign cfg_claim_o = (idx_hit || dat_hit) && (io_req_i.rd || io_req_i.wr);
   assign cur = ldn_reg[3:0];
   assign cur_kind = fn_kind(ldn_reg);

   // Read view of the selected bank; holes read zero
   always_comb
   begin
      bank_rdata = 8'h00;
      if (index_reg == `IDX_LDN)
      begin
         bank_rdata = ldn_reg;
      end
      else if (cur_kind != FN_NONE)
      begin
         if (index_reg == `IDX_ACTIVATE)
         begin
            bank_rdata = {7'h00, act_reg[cur]};
         end
         else if (index_reg == `IDX_BASE_HI && relocatable(cur_kind))
         begin
            bank_rdata = base_hi_reg[cur];
         end
         else if (index_reg == `IDX_BASE_LO && relocatable(cur_kind))
         begin
            bank_rdata = base_lo_reg[cur];
         end
         else if (index_reg == `IDX_IRQ_PRI)
         begin
            bank_rdata = irq_reg[cur];
         end
         else if (index_reg == `IDX_IRQ_SEC && cur_kind == FN_KEYBOARD)
         begin
            bank_rdata = irq2_reg[cur];
         end
         else if (index_reg == `IDX_DMA_SEL && (cur_kind == FN_FLOPPY || cur_kind == FN_PARALLEL))
         begin
            bank_rdata = dma_reg[cur];
         end
         else if (index_reg >= `IDX_VENDOR_LO && index_reg <= `IDX_VENDOR_HI)
         begin
            bank_rdata = vendor_rdata_i;
         end
         // 0x71, 0x73, 0x75, 0x76-0xDF, 0xFF fall through to zero
      end
   end

   always_comb
   begin
      index_next = index_reg;
      ldn_next = ldn_reg;
      rdata_next = rdata_reg;
      rvalid_next = 1'b0;
      vwr_next = 1'b0;
      vwdata_next = vwdata_reg;
      act_next = act_reg;
      base_hi_next = base_hi_reg;
      base_lo_next = base_lo_reg;
      irq_next = irq_reg;
      irq2_next = irq2_reg;
      dma_next = dma_reg;
      // Power/control writes land on the same bit as activate
      for (int d = 0; d < NDEV; d++)
      begin
         if (pwr_wr_i[d])
         begin
            act_next[d] = pwr_wdata_i[d];
         end
      end
      if (io_req_i.rd && (idx_hit || dat_hit))
      begin
         rdata_next = idx_hit ? index_reg : bank_rdata;
         rvalid_next = 1'b1;
      end
      if (io_req_i.wr && idx_hit)
      begin
         index_next = io_req_i.wdata;
      end
      if (io_req_i.wr && dat_hit)
      begin
         if (index_reg == `IDX_LDN)
         begin
            ldn_next = io_req_i.wdata;
         end
         else if (cur_kind != FN_NONE)
         begin
            // Host write wins over a power write in the same cycle
            if (index_reg == `IDX_ACTIVATE)
            begin
               act_next[cur] = io_req_i.wdata[`ACT_BIT];
            end
            else if (index_reg == `IDX_BASE_HI && relocatable(cur_kind))
            begin
               base_hi_next[cur] = io_req_i.wdata;
            end
            else if (index_reg == `IDX_BASE_LO && relocatable(cur_kind))
            begin
               base_lo_next[cur] = io_req_i.wdata;
            end
            else if (index_reg == `IDX_IRQ_PRI)
            begin
               irq_next[cur] = io_req_i.wdata;
            end
            else if (index_reg == `IDX_IRQ_SEC && cur_kind == FN_KEYBOARD)
            begin
               irq2_next[cur] = io_req_i.wdata;
            end
            else if (index_reg == `IDX_DMA_SEL && (cur_kind == FN_FLOPPY || cur_kind == FN_PARALLEL))
            begin
               dma_next[cur] = io_req_i.wdata;
            end
            else if (index_reg >= `IDX_VENDOR_LO && index_reg <= `IDX_VENDOR_HI)
            begin
               vwr_next = 1'b1;
               vwdata_next = io_req_i.wdata;
            end
         end
      end
      // Soft reset returns the banks to their reset values but keeps the port index and device number
      if (soft_reset_i)
      begin
         for (int d = 0; d < NDEV; d++)
         begin
            act_next[d] = 1'b0;
            base_hi_next[d] = 8'h00;
            base_lo_next[d] = 8'h00;
            irq_next[d] = irq_rst(fn_kind(8'(d)));
            irq2_next[d] = `IRQ_SEC_RST;
            dma_next[d] = dma_rst(fn_kind(8'(d)));
         end
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         index_reg <= 8'h00;
         ldn_reg <= 8'h00;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
         vwr_reg <= 1'b0;
         vwdata_reg <= 8'h00;
         act_reg <= '0;
         for (int d = 0; d < NDEV; d++)
         begin
            base_hi_reg[d] <= 8'h00;
            base_lo_reg[d] <= 8'h00;
            irq_reg[d] <= irq_rst(fn_kind(8'(d)));
            irq2_reg[d] <= `IRQ_SEC_RST;
            dma_reg[d] <= dma_rst(fn_kind(8'(d)));
         end
      end
      else
      begin
         index_reg <= index_next;
         ldn_reg <= ldn_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         vwr_reg <= vwr_next;
         vwdata_reg <= vwdata_next;
         act_reg <= act_next;
         base_hi_reg <= base_hi_next;
         base_lo_reg <= base_lo_next;
         irq_reg <= irq_next;
         irq2_reg <= irq2_next;
         dma_reg <= dma_next;
      end
   end

   assign io_rdata_o = rdata_reg;
   assign io_rvalid_o = rvalid_reg;
   assign vendor_wr_o = vwr_reg;
   assign vendor_wdata_o = vwdata_reg;
   assign vendor_idx_o = index_reg;
   assign vendor_ldn_o = ldn_reg;

   // ****************************************************
   // Function I/O decode
   // ****************************************************
   logic upper_ok;
   logic cycle;
   logic [15:0] pp_base;

   // Upper address bits only qualify when 16-bit decode is enabled
   assign upper_ok = !addr16_qual_i || io_req_i.addr[15:12] == 4'h0;
   assign cycle = (io_req_i.rd || io_req_i.wr) && upper_ok;
   assign pp_base = {base_hi_reg[`LDN_PARALLEL], base_lo_reg[`LDN_PARALLEL]};
   assign pp_epp_ok_o = pp_base[2:0] == 3'h0;

   always_comb
   begin
      logic [11:0] a;
      logic [15:0] b;
      logic [11:0] ext;
      logic hit;
      fn_kind_t k;
      a = io_req_i.addr[11:0];
      b = 16'h0000;
      ext = 12'h000;
      hit = 1'b0;
      k = FN_NONE;
      fn_sel_o = '0;
      for (int d = 0; d < NDEV; d++)
      begin
         k = fn_kind(8'(d));
         b = {base_hi_reg[d], base_lo_reg[d]};
         ext = b[11:0] + `PP_EXT_OFFSET;
         hit = 1'b0;
         unique case (k)
            FN_FLOPPY: hit = a[11:3] == b[11:3] && a[2:0] != `FLOPPY_HOLE_OFS;
            FN_PARALLEL: hit = (a[11:2] == b[11:2] && a[1:0] != 2'h3)
               || (b[2] == 1'b0 && a[11:3] == b[11:3])
               || (a[11:2] == ext[11:2] && a[1:0] != 2'h3);
            FN_SERIAL: hit = a[11:3] == b[11:3];
            FN_MIDI: hit = a[11:1] == b[11:1];
            FN_KEYBOARD: hit = {4'h0, a} == `KBD_DATA_ADDR || {4'h0, a} == `KBD_CMD_ADDR;
            FN_GAME: hit = a == b[11:0];
            FN_NONE: hit = 1'b0;
         endcase
         // Bad base or inactive function: cycle is left alone
         fn_sel_o[d] = cycle && hit && act_reg[d] && base_ok(k, b) && !cfg_claim_o;
      end
   end

   // ****************************************************
   // Configuration outputs
   // ****************************************************
   always_comb
   begin
      for (int d = 0; d < NDEV; d++)
      begin
         ld_cfg_o[d].active = act_reg[d];
         ld_cfg_o[d].irq_edge_high = 1'b1;
         ld_cfg_o[d].base = {base_hi_reg[d], base_lo_reg[d]};
         ld_cfg_o[d].irq = irq_reg[d];
         ld_cfg_o[d].irq2 = irq2_reg[d];
         ld_cfg_o[d].dma = dma_reg[d];
      end
   end

   // Activate and power share one bit, so on follows whichever of the two wrote it last
   assign dev_on_o = act_reg;

endmodule // ldcfg_bank

/* dv/ldcfg_bank_chk.sv */
// Port checker of the logical device configuration bank
`timescale 1ns/10ps
`include "ldcfg_regs.svh"
module ldcfg_bank_chk
   import ldcfg_pkg::*;
#(
   parameter int NDEV = 10,
   parameter logic [15:0] CFG_PORT = `CFG_PORT_DEFAULT
)
(
   // Clock and resets
   input logic sys_clk_i,
   input logic rst_b_i,
   input logic soft_reset_i,
   // Host side
   input io_req_t io_req_i,
   input logic cfg_state_i,
   input logic cfg_claim_o,
   input logic io_rvalid_o,
   // Power/control strobes
   input logic [NDEV-1:0] pwr_wr_i,
   input logic [NDEV-1:0] pwr_wdata_i,
   // Function side
   input logic [NDEV-1:0] dev_on_o,
   input logic vendor_wr_o,
   input logic [7:0] vendor_idx_o,
   input ld_cfg_t [NDEV-1:0] ld_cfg_o,
   input logic [NDEV-1:0] fn_sel_o,
   input logic pp_epp_ok_o
);
   // ****************************************
   // Properties
   // ****************************************
   logic [NDEV-1:0] act;
   always_comb
   begin
      for (int d = 0; d < NDEV; d++)
      begin
         act[d] = ld_cfg_o[d].active;
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_data_rd;
      cfg_state_i && io_req_i.rd && io_req_i.addr == CFG_PORT + 16'h0001;
   endsequence
   // Power writes alone, so a host activate write cannot mask the link
   sequence s_pwr_wr;
      |pwr_wr_i && !soft_reset_i && !(io_req_i.wr && cfg_claim_o);
   endsequence
   property p_rd_ans; s_data_rd |=> io_rvalid_o; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_claim; cfg_claim_o |-> cfg_state_i; endproperty
   a_claim: assert property (p_claim) else $error("claim outside config state");
   property p_on; s_pwr_wr |=> ((dev_on_o ^ $past(pwr_wdata_i)) & $past(pwr_wr_i)) == '0; endproperty
   a_on: assert property (p_on) else $error("on flag differs from activate");
   property p_rsvd; !(fn_sel_o[1] || fn_sel_o[2] || fn_sel_o[6] || fn_sel_o[8]); endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved function selected");
   property p_sel_on; (fn_sel_o & ~act) == '0; endproperty
   a_sel_on: assert property (p_sel_on) else $error("inactive function selected");
   property p_kbd; fn_sel_o[7] |-> io_req_i.addr[11:0] inside {12'h060, 12'h064}; endproperty
   a_kbd: assert property (p_kbd) else $error("keyboard decode off");
   property p_fdc;
      fn_sel_o[0] |-> io_req_i.addr[11:3] == ld_cfg_o[0].base[11:3] && io_req_i.addr[2:0] != 3'h6;
   endproperty
   a_fdc: assert property (p_fdc) else $error("floppy decode off");
   property p_game; fn_sel_o[9] |-> io_req_i.addr[11:0] == ld_cfg_o[9].base[11:0]; endproperty
   a_game: assert property (p_game) else $error("game decode off");
   property p_epp; pp_epp_ok_o == (ld_cfg_o[3].base[2:0] == 3'h0); endproperty
   a_epp: assert property (p_epp) else $error("epp enable wrong");
   property p_dma_rst;
      $rose(rst_b_i) || $past(soft_reset_i) |-> ld_cfg_o[0].dma == 8'h02 && ld_cfg_o[3].dma == 8'h04;
   endproperty
   a_dma_rst: assert property (p_dma_rst) else $error("dma reset value wrong");
   property p_vendor;
      vendor_wr_o |-> vendor_idx_o inside {[8'hE0:8'hFE]} && $past(cfg_state_i && io_req_i.wr);
   endproperty
   a_vendor: assert property (p_vendor) else $error("vendor write wrong");
   property p_edge; ld_cfg_o[0].irq_edge_high && ld_cfg_o[4].irq_edge_high; endproperty
   a_edge: assert property (p_edge) else $error("interrupt not edge high");
endmodule // ldcfg_bank_chk

/* dv/ldcfg_host_model.sv */
// Host model issuing configuration and function I/O cycles
`timescale 1ns/10ps
module ldcfg_host_model
   import ldcfg_pkg::*;
(
   // Clock
   input logic sys_clk_i,
   // Host cycle
   output io_req_t io_req_o,
   output logic cfg_state_o,
   input logic [7:0] io_rdata_i
);
   // ****************************************
   // Cycles
   // ****************************************
   initial
   begin
      io_req_o = '0;
      cfg_state_o = 1'b0;
   end
   task automatic cyc(input logic [15:0] a, input logic r, input logic [7:0] d);
      @(posedge sys_clk_i);
      io_req_o <= '{a, r, !r, d};
      @(posedge sys_clk_i);
      // Released address and data lines show the inverse, never a stale copy
      io_req_o <= '{~a, 1'b0, 1'b0, ~d};
   endtask
   task automatic cfg(input logic on);
      @(posedge sys_clk_i);
      cfg_state_o <= on;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      cyc(a, 1'b1, 8'h00);
      @(posedge sys_clk_i);
      d = io_rdata_i;
   endtask
endmodule // ldcfg_host_model

/* dv/ldcfg_bank_bench.sv */
// Self-checking bench of the logical device configuration bank
`timescale 1ns/10ps
`include "ldcfg_regs.svh"
bind ldcfg_bank ldcfg_bank_chk #(.NDEV(NDEV), .CFG_PORT(CFG_PORT)) ldcfg_bank_chk_i (.sys_clk_i, .rst_b_i,
   .soft_reset_i, .io_req_i, .cfg_state_i, .cfg_claim_o, .io_rvalid_o, .pwr_wr_i, .pwr_wdata_i, .dev_on_o,
   .vendor_wr_o,
   .vendor_idx_o, .ld_cfg_o, .fn_sel_o, .pp_epp_ok_o);
module ldcfg_bank_bench
   import ldcfg_pkg::*;
;
   localparam int NDEV = 10;
   localparam logic [15:0] CP = `CFG_PORT_DEFAULT;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic soft_reset_i = 1'b0;
   logic addr16_qual_i = 1'b1;
   logic [NDEV-1:0] pwr_wr_i = '0;
   logic [NDEV-1:0] pwr_wdata_i = '0;
   logic [7:0] vendor_rdata_i = 8'h00;
   io_req_t io_req_i;
   logic cfg_state_i;
   logic [7:0] io_rdata_o;
   logic [7:0] vendor_ldn_o;
   logic [7:0] vendor_wdata_o;
   logic [NDEV-1:0] dev_on_o;
   ld_cfg_t [NDEV-1:0] ld_cfg_o;
   logic [NDEV-1:0] fn_sel_o;
   logic pp_epp_ok_o;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   int fl[6] = '{0, 3, 4, 5, 7, 9};
   logic [7:0] hole[9] = '{8'h71, 8'h73, 8'h75, 8'h76, 8'hA8, 8'hA9, 8'hDF, 8'hFF, 8'h00};
   logic [7:0] wq[6];
   logic [7:0] v;
   logic [7:0] w;
   logic [7:0] r;
   logic [15:0] b;

   always #12.5 sys_clk_i = ~sys_clk_i;

   ldcfg_bank #(.NDEV(NDEV)) ldcfg_bank_i (.sys_clk_i, .rst_b_i, .soft_reset_i, .io_req_i, .cfg_state_i,
      .addr16_qual_i, .cfg_claim_o(), .io_rdata_o, .io_rvalid_o(), .pwr_wr_i, .pwr_wdata_i, .dev_on_o,
      .vendor_rdata_i, .vendor_wr_o(), .vendor_idx_o(), .vendor_ldn_o, .vendor_wdata_o, .ld_cfg_o,
      .fn_sel_o, .pp_epp_ok_o);
   ldcfg_host_model ldcfg_host_model_i (.sys_clk_i, .io_req_o(io_req_i), .cfg_state_o(cfg_state_i),
      .io_rdata_i(io_rdata_o));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic results;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkb(input string n, input logic e, input logic g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic cw(input logic [7:0] i, input logic [7:0] d);
      ldcfg_host_model_i.cyc(CP, 1'b0, i);
      ldcfg_host_model_i.cyc(CP + 16'h0001, 1'b0, d);
   endtask
   task automatic cr(input logic [7:0] i, output logic [7:0] d);
      ldcfg_host_model_i.cyc(CP, 1'b0, i);
      ldcfg_host_model_i.rd(CP + 16'h0001, d);
   endtask
   task automatic sel(input logic [15:0] a, input int k, input logic e);
      fork
         ldcfg_host_model_i.cyc(a, 1'b1, 8'h00);
         begin
            // Look mid-cycle, while the request stands and the decode has settled
            @(posedge sys_clk_i);
            @(negedge sys_clk_i);
            chkb("fn_sel", e, fn_sel_o[k]);
         end
      join
   endtask
   task automatic dev(input int n, input logic [15:0] a);
      cw(`IDX_LDN, 8'(n));
      cw(`IDX_BASE_HI, a[15:8]);
      cw(`IDX_BASE_LO, a[7:0]);
      cw(`IDX_ACTIVATE, 8'h01);
   endtask
   task automatic pw(input logic x);
      @(posedge sys_clk_i);
      pwr_wr_i[3] <= 1'b1;
      pwr_wdata_i[3] <= x;
      @(posedge sys_clk_i);
      pwr_wr_i[3] <= 1'b0;
   endtask
   function automatic logic [7:0] exp_irq(input int n);
      case (n)
         0: return 8'h06;
         3: return 8'h07;
         4: return 8'h04;
         5: return 8'h05;
         7: return 8'h01;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] exp_dma(input int n);
      return n == 0 ? 8'h02 : n == 3 ? 8'h04 : 8'h00;
   endfunction

   // Hang guard, far above the thousand or so cycles the run needs
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end

   initial
   begin
      v = 8'($urandom(85092));
      repeat (16) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      ldcfg_host_model_i.cfg(1'b1);
      foreach (fl[i])
      begin
         cw(`IDX_LDN, 8'(fl[i]));
         cr(`IDX_IRQ_PRI, v);
         chk8("irq_reset", exp_irq(fl[i]), v);
         cr(`IDX_DMA_SEL, v);
         chk8("dma_reset", exp_dma(fl[i]), v);
         foreach (hole[j])
         begin
            r = (j == 8) ? 8'h76 + 8'($urandom_range(105)) : hole[j];
            cw(r, 8'($urandom));
            cr(r, v);
            chk8("hole", 8'h00, v);
         end
         w = 8'($urandom_range(15));
         wq[i] = w;
         cw(`IDX_IRQ_SEC, w);
         cr(`IDX_IRQ_SEC, v);
         chk8("irq_sec", fl[i] == 7 ? w : 8'h00, v);
         cw(`IDX_DMA_SEL, w & 8'h07);
         cr(`IDX_DMA_SEL, v);
         chk8("dma_sel", exp_dma(fl[i]) != 8'h00 ? w & 8'h07 : 8'h00, v);
         cw(`IDX_IRQ_PRI, w);
         cr(`IDX_IRQ_PRI, v);
         chk8("irq_pri", w, v);
      end
      cw(`IDX_LDN, 8'h00);
      cr(`IDX_IRQ_PRI, v);
      chk8("bank_select", wq[0], v);
      cw(`IDX_DMA_SEL, 8'h01);
      @(posedge sys_clk_i);
      soft_reset_i <= 1'b1;
      @(posedge sys_clk_i);
      soft_reset_i <= 1'b0;
      cr(`IDX_DMA_SEL, v);
      chk8("dma_soft", 8'h02, v);
      ldcfg_host_model_i.cfg(1'b0);
      cw(`IDX_IRQ_PRI, 8'h0A);
      ldcfg_host_model_i.cfg(1'b1);
      cr(`IDX_IRQ_PRI, v);
      chk8("irq_closed", 8'h06, v);
      // Keep base + 400h below 1000h, where address qualification would hide it
      b = 16'h0104 + 16'($urandom_range(350)) * 16'h0008;
      dev(3, b);
      repeat (2) @(posedge sys_clk_i);
      chkb("dev_on", 1'b1, dev_on_o[3]);
      pw(1'b0);
      cr(`IDX_ACTIVATE, v);
      chk8("act_link", 8'h00, v);
      chkb("dev_on", 1'b0, dev_on_o[3]);
      pw(1'b1);
      cr(`IDX_ACTIVATE, v);
      chk8("act_link", 8'h01, v);
      chkb("epp", 1'b0, pp_epp_ok_o);
      sel(b + 16'h0400, 3, 1'b1);
      sel(b + 16'h0002, 3, 1'b1);
      b = b - 16'h0004;
      cw(`IDX_BASE_LO, b[7:0]);
      @(posedge sys_clk_i);
      chkb("epp", 1'b1, pp_epp_ok_o);
      b = 16'h0100 + 16'($urandom_range(479)) * 16'h0008;
      dev(0, b);
      for (int o = 0; o < 8; o++)
      begin
         sel(b + 16'(o), 0, o != 6);
      end
      sel(b | 16'h1000, 0, 1'b0);
      addr16_qual_i <= 1'b0;
      sel(b | 16'h1000, 0, 1'b1);
      addr16_qual_i <= 1'b1;
      cw(`IDX_BASE_HI, 8'h00);
      sel({8'h00, b[7:0]}, 0, 1'b0);
      b = 16'h0100 + 16'($urandom_range(479)) * 16'h0008;
      dev(4, b);
      sel(b + 16'h0007, 4, 1'b1);
      sel(b + 16'h0008, 4, 1'b0);
      dev(7, 16'h0000);
      sel(16'h0060, 7, 1'b1);
      sel(16'h0064, 7, 1'b1);
      sel(16'h0061, 7, 1'b0);
      b = 16'h0100 + 16'($urandom_range(3839));
      dev(9, b);
      sel(b, 9, 1'b1);
      sel(b + 16'h0001, 9, 1'b0);
      cw(`IDX_ACTIVATE, 8'h00);
      sel(b, 9, 1'b0);
      cw(`IDX_LDN, 8'h01);
      cw(`IDX_BASE_HI, 8'h03);
      cr(`IDX_BASE_HI, v);
      chk8("rsvd_ldn", 8'h00, v);
      @(posedge sys_clk_i);
      vendor_rdata_i <= 8'($urandom);
      cw(`IDX_LDN, 8'h03);
      r = 8'hE0 + 8'($urandom_range(30));
      w = 8'($urandom);
      cw(r, w);
      @(negedge sys_clk_i);
      chk8("vendor_wdata", w, vendor_wdata_o);
      chk8("vendor_ldn", 8'h03, vendor_ldn_o);
      cr(r, v);
      chk8("vendor", vendor_rdata_i, v);
      @(posedge sys_clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      cr(`IDX_DMA_SEL, v);
      chk8("dma_hard", 8'h02, v);
      results();
   end
endmodule // ldcfg_bank_bench
